/* File: verilog/lfc_pkg.sv */
package lfc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************

  // Register offsets on the serial control register port.
  localparam logic [7:0]  LED_FAULT_CONFIG_OFS   = 8'h06;
  localparam logic [7:0]  SUPPLY_IRQ_ENABLES_OFS = 8'h08;

  // Reset values.
  localparam logic [15:0] LED_FAULT_CONFIG_RST   = 16'h0100;
  localparam logic [15:0] SUPPLY_IRQ_ENABLES_RST = 16'h2AAA;
  localparam logic [6:0]  IRQ_EN_RST             = 7'h7F;

  // Fault configuration field positions.
  localparam int          GND_DETECT_BIT         = 8;
  localparam int          MUST_ZERO_HI           = 7;
  localparam int          MUST_ZERO_LO           = 4;
  localparam int          STRING_COUNT           = 4;

  // Interrupt enable fields: seven two-bit fields from bit 0 upward.
  localparam int          IRQ_FIELDS             = 7;
  localparam int          IRQ_FIELD_W            = 2;

  // Field codes for the interrupt enables.
  localparam logic [1:0]  IRQ_RD_OFF             = 2'h0;
  localparam logic [1:0]  IRQ_RD_ON              = 2'h2;
  localparam logic [1:0]  IRQ_WR_OFF             = 2'h1;
  localparam logic [1:0]  IRQ_WR_ON              = 2'h3;

endpackage : lfc_pkg

/* File: verilog/lfc_regs.sv */
// Operation
// R1 - Bit 8 enables short-to-ground detection, resets one.
// R2 - Bits 3..0 suppress per-string short faults.
// R3 - Host writes zeros to bits 7..4.
// R4 - Fault config resets 100h, bits 15..9 zero.
// R5 - Enable fields read 0h off, 2h on.
// R6 - Write 1h disables, 3h enables.
// R7 - Boost sync missing enable at bits 13..12.
// R8 - Charge pump enable at bits 11..10.
// R9 - Pump capacitor missing enable at bits 9..8.
// R10 - Supply enables reset 2AAAh, lower fields listed.
// R11 - Supply bits 15..14 reserved, reset zero.
// R12 - Writing 0h or 2h leaves enable unchanged.
`timescale 1ns/1ps
`default_nettype none

module lfc_regs (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        clk_en_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  output logic             short_to_ground_detect_en_o,
  output logic      [3:0]  string_short_fault_off_o,
  output logic      [6:0]  supply_irq_en_o
);

  // ****************************************************************
  // Storage
  // ****************************************************************

  logic [8:0]  fault_cfg_r;
  logic [6:0]  irq_en_r;
  logic [6:0]  irq_en_nxt;
  logic [15:0] irq_rd;
  logic [15:0] reg_rdata_r;
  logic        wr_fault;
  logic        wr_supply;

  // Address decode of the two writable words.
  assign wr_fault  = reg_wr_i && (reg_addr_i == lfc_pkg::LED_FAULT_CONFIG_OFS);
  assign wr_supply = reg_wr_i && (reg_addr_i == lfc_pkg::SUPPLY_IRQ_ENABLES_OFS);

  // Fault configuration keeps bits 8..0; bits 15..9 are not stored and read zero.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fault_cfg_r <= lfc_pkg::LED_FAULT_CONFIG_RST[8:0]; // see R4
    end else if (clk_en_i && wr_fault) begin
      fault_cfg_r <= reg_wdata_i[8:0]; // see R1, R2
    end
  end

  // ****************************************************************
  // Interrupt enable fields
  // ****************************************************************

  // Each field decodes its write code; other codes hold the state.
  genvar g;
  generate
    for (g = 0; g < lfc_pkg::IRQ_FIELDS; g++) begin : g_irq
      logic [1:0] code;
      assign code = reg_wdata_i[2*g+1:2*g];
      // Codes 0h and 2h fall through to the held state, so fields can be skipped.
      assign irq_en_nxt[g] = (wr_supply && code == lfc_pkg::IRQ_WR_ON)  ? 1'b1 : // see R6
                             (wr_supply && code == lfc_pkg::IRQ_WR_OFF) ? 1'b0 : // see R6
                             irq_en_r[g]; // see R12
      // Read view reports 2h when enabled and 0h when disabled.
      assign irq_rd[2*g+1:2*g] = irq_en_r[g] ? lfc_pkg::IRQ_RD_ON
                                             : lfc_pkg::IRQ_RD_OFF; // see R5
    end
  endgenerate
  assign irq_rd[15:14] = 2'h0; // see R11

  // Enable state, all fields enabled out of reset.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_en_r <= lfc_pkg::IRQ_EN_RST; // see R10
    end else if (clk_en_i) begin
      irq_en_r <= irq_en_nxt;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************

  // Read data registered on a read strobe; unmapped offsets read zero.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_r <= 16'h0000;
    end else if (clk_en_i && reg_rd_i) begin
      case (reg_addr_i)
        lfc_pkg::LED_FAULT_CONFIG_OFS:   reg_rdata_r <= {7'h00, fault_cfg_r};
        lfc_pkg::SUPPLY_IRQ_ENABLES_OFS: reg_rdata_r <= irq_rd;
        default:                         reg_rdata_r <= 16'h0000;
      endcase
    end
  end

  assign reg_rdata_o                 = reg_rdata_r;
  assign short_to_ground_detect_en_o = fault_cfg_r[lfc_pkg::GND_DETECT_BIT]; // see R1
  assign string_short_fault_off_o    = fault_cfg_r[3:0]; // see R2
  assign supply_irq_en_o             = irq_en_r; // see R7, R8, R9

  // ****************************************************************
  // Checks
  // ****************************************************************

  sequence s_wr_on(int b);
    clk_en_i && wr_supply && reg_wdata_i[b+:2] == 2'h3;
  endsequence

  property p_reset_cfg;
    @(posedge clk_sys_i) $past(rst_i) |-> fault_cfg_r == 9'h100;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("fault config reset wrong"); // see R4

  property p_reset_irq;
    @(posedge clk_sys_i) $past(rst_i) |-> irq_rd == 16'h2AAA;
  endproperty
  a_reset_irq: assert property (p_reset_irq) else $error("irq enables reset wrong"); // see R10

  property p_gnd_wr;
    @(posedge clk_sys_i) disable iff (rst_i)
      clk_en_i && wr_fault |=> short_to_ground_detect_en_o == $past(reg_wdata_i[8]);
  endproperty
  a_gnd_wr: assert property (p_gnd_wr) else $error("detect enable not written"); // see R1

  property p_str_wr;
    @(posedge clk_sys_i) disable iff (rst_i)
      clk_en_i && wr_fault |=> string_short_fault_off_o == $past(reg_wdata_i[3:0]);
  endproperty
  a_str_wr: assert property (p_str_wr) else $error("string bits not written"); // see R2

  property p_sync_on;
    @(posedge clk_sys_i) disable iff (rst_i) s_wr_on(12) |=> irq_rd[13:12] == 2'h2;
  endproperty
  a_sync_on: assert property (p_sync_on) else $error("boost sync enable failed"); // see R7

  property p_cp_off;
    @(posedge clk_sys_i) disable iff (rst_i)
      clk_en_i && wr_supply && reg_wdata_i[11:10] == 2'h1 |=> !supply_irq_en_o[5];
  endproperty
  a_cp_off: assert property (p_cp_off) else $error("charge pump disable failed"); // see R8

  property p_cap_on;
    @(posedge clk_sys_i) disable iff (rst_i) s_wr_on(8) |=> supply_irq_en_o[4];
  endproperty
  a_cap_on: assert property (p_cap_on) else $error("pump cap enable failed"); // see R9

  property p_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
      clk_en_i && wr_supply && reg_wdata_i[1:0] inside {2'h0, 2'h2}
      |=> supply_irq_en_o[0] == $past(supply_irq_en_o[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("enable changed on hold code"); // see R12

  property p_rsv;
    @(posedge clk_sys_i) disable iff (rst_i)
      reg_rdata_o[15:14] == 2'h0 && (irq_rd[14] == 1'b0);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits nonzero"); // see R11, R5

  // ****************************************************************
  // Reset and freeze checks
  // ****************************************************************

  // A disable code written into the field that starts at bit b.
  sequence s_wr_off(int b);
    clk_en_i && wr_supply && reg_wdata_i[b+:2] == 2'h1;
  endsequence

  // After reset the read port is quiet and the config outputs are at defaults.
  property p_reset_rdata;
    @(posedge clk_sys_i) $past(rst_i) |-> reg_rdata_o == 16'h0000;
  endproperty
  a_reset_rdata: assert property (p_reset_rdata) else $error("read data not cleared");

  // Detection starts enabled and no string fault is suppressed.
  property p_reset_outs;
    @(posedge clk_sys_i) $past(rst_i) |-> short_to_ground_detect_en_o
      && string_short_fault_off_o == 4'h0;
  endproperty
  a_reset_outs: assert property (p_reset_outs) else $error("config outputs reset wrong"); // see R1, R2

  // With the clock enable low nothing in the block may move.
  property p_freeze;
    @(posedge clk_sys_i) disable iff (rst_i)
      !clk_en_i |=> $stable(fault_cfg_r) && $stable(irq_en_r) && $stable(reg_rdata_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  // Without an accepted fault write the config word must hold.
  property p_cfg_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
      !(clk_en_i && wr_fault) |=> $stable(fault_cfg_r);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("fault config changed"); // see R1, R2

  // Without an accepted supply write the enables must hold.
  property p_irq_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
      !(clk_en_i && wr_supply) |=> $stable(irq_en_r);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("enables changed unwritten"); // see R12

  // ****************************************************************
  // Read port checks
  // ****************************************************************

  // A fault config read returns the stored bits with the top seven zero.
  property p_rd_fault;
    @(posedge clk_sys_i) disable iff (rst_i)
      clk_en_i && reg_rd_i && reg_addr_i == lfc_pkg::LED_FAULT_CONFIG_OFS
      |=> reg_rdata_o == {7'h00, $past(fault_cfg_r)};
  endproperty
  a_rd_fault: assert property (p_rd_fault) else $error("fault config read wrong"); // see R4

  // A supply read returns the encoded view of the enables.
  property p_rd_irq;
    @(posedge clk_sys_i) disable iff (rst_i)
      clk_en_i && reg_rd_i && reg_addr_i == lfc_pkg::SUPPLY_IRQ_ENABLES_OFS
      |=> reg_rdata_o == $past(irq_rd);
  endproperty
  a_rd_irq: assert property (p_rd_irq) else $error("supply enables read wrong"); // see R5

  // Offsets outside the two words read back zero.
  property p_rd_other;
    @(posedge clk_sys_i) disable iff (rst_i)
      clk_en_i && reg_rd_i && reg_addr_i != lfc_pkg::LED_FAULT_CONFIG_OFS
      && reg_addr_i != lfc_pkg::SUPPLY_IRQ_ENABLES_OFS |=> reg_rdata_o == 16'h0000;
  endproperty
  a_rd_other: assert property (p_rd_other) else $error("unmapped read nonzero");

  // Read data stands until the next accepted read.
  property p_rd_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
      !(clk_en_i && reg_rd_i) |=> $stable(reg_rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data did not hold");

  // ****************************************************************
  // Field code checks
  // ****************************************************************

  // Boost sync field turns off on code 1h.
  property p_sync_off;
    @(posedge clk_sys_i) disable iff (rst_i) s_wr_off(12) |=> !supply_irq_en_o[6];
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("boost sync disable failed"); // see R7

  // Charge pump field turns on on code 3h.
  property p_cp_on;
    @(posedge clk_sys_i) disable iff (rst_i) s_wr_on(10) |=> supply_irq_en_o[5];
  endproperty
  a_cp_on: assert property (p_cp_on) else $error("charge pump enable failed"); // see R8

  // Pump capacitor field turns off on code 1h.
  property p_cap_off;
    @(posedge clk_sys_i) disable iff (rst_i) s_wr_off(8) |=> !supply_irq_en_o[4];
  endproperty
  a_cap_off: assert property (p_cap_off) else $error("pump cap disable failed"); // see R9

  // Overcurrent field turns on on code 3h.
  property p_oc_on;
    @(posedge clk_sys_i) disable iff (rst_i) s_wr_on(6) |=> supply_irq_en_o[3];
  endproperty
  a_oc_on: assert property (p_oc_on) else $error("overcurrent enable failed"); // see R10

  // Core undervoltage field turns off on code 1h.
  property p_core_off;
    @(posedge clk_sys_i) disable iff (rst_i) s_wr_off(4) |=> !supply_irq_en_o[2];
  endproperty
  a_core_off: assert property (p_core_off) else $error("core uv disable failed"); // see R10

  // Input overvoltage field turns on on code 3h.
  property p_ov_on;
    @(posedge clk_sys_i) disable iff (rst_i) s_wr_on(2) |=> supply_irq_en_o[1];
  endproperty
  a_ov_on: assert property (p_ov_on) else $error("overvoltage enable failed"); // see R10

  // Input undervoltage field turns off on code 1h.
  property p_uv_off;
    @(posedge clk_sys_i) disable iff (rst_i) s_wr_off(0) |=> !supply_irq_en_o[0];
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("undervoltage disable failed"); // see R6

endmodule : lfc_regs

`default_nettype wire

/* File: testbench/lfc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Host model: launches each request just after an edge and drops it one edge later.
module lfc_host (
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] reg_rdata_i,
  output var  logic [7:0]  reg_addr_o,
  output var  logic        reg_wr_o,
  output var  logic [15:0] reg_wdata_o,
  output var  logic        reg_rd_o
);
  // The port starts idle.
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 16'h0000;
    reg_rd_o = 1'b0;
  end
  // Writes one word. Bits 7..4 of the fault register always go out as zero.
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_wdata_o <= (a == lfc_pkg::LED_FAULT_CONFIG_OFS) ? (d & 16'hff0f) : d;
    reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
  endtask : wr_reg
  // Reads one word once the registered answer has landed.
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    #1 d = reg_rdata_i;
  endtask : rd_reg
endmodule : lfc_host
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module tb;
  logic        clk_sys_i, rst_i, clk_en_i, reg_wr_i, reg_rd_i;
  logic [7:0]  reg_addr_i, addr;
  logic [15:0] reg_wdata_i, reg_rdata_o, rd_val, data, fault_exp;
  logic        short_to_ground_detect_en_o;
  logic [3:0]  string_short_fault_off_o;
  logic [6:0]  supply_irq_en_o, irq_exp;
  logic [15:0] corner [4] = '{16'h5555, 16'haaaa, 16'hffff, 16'h0000};
  int          n_mismatch, total_checks, cycles;
  lfc_regs lfc_regs_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .short_to_ground_detect_en_o(short_to_ground_detect_en_o),
    .string_short_fault_off_o(string_short_fault_off_o), .supply_irq_en_o(supply_irq_en_o));
  lfc_host lfc_host_inst (.clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata_o),
    .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i),
    .reg_rd_o(reg_rd_i));
  // Read image of the enable fields: 2h when on, 0h when off.
  function automatic logic [15:0] irq_word(input logic [6:0] en);
    irq_word = 16'h0000;
    for (int k = 0; k < 7; k++) irq_word[2*k +: 2] = en[k] ? 2'h2 : 2'h0;
  endfunction : irq_word
  // Only codes 1h and 3h change a field; 0h and 2h keep it.
  function automatic logic [6:0] irq_next(input logic [6:0] en, input logic [15:0] d);
    irq_next = en;
    for (int k = 0; k < 7; k++) begin
      if (d[2*k +: 2] == 2'h3) irq_next[k] = 1'b1;
      else if (d[2*k +: 2] == 2'h1) irq_next[k] = 1'b0;
    end
  endfunction : irq_next
  // Reads both registers back and checks the config outputs.
  task automatic check_all();
    lfc_host_inst.rd_reg(8'h06, rd_val);
    `CHK(rd_val, fault_exp)
    lfc_host_inst.rd_reg(8'h08, rd_val);
    `CHK(rd_val, irq_word(irq_exp))
    `CHK(short_to_ground_detect_en_o, fault_exp[8])
    `CHK(string_short_fault_off_o, fault_exp[3:0])
    `CHK(supply_irq_en_o, irq_exp)
  endtask : check_all
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // Clock and hang guard.
  always #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // Reset values, field codes, reserved bits and unmapped offsets.
  initial begin
    clk_sys_i = 1'b0;
    rst_i = 1'b1;
    clk_en_i = 1'b1;
    fault_exp = 16'h0100;
    irq_exp = 7'h7f;
    rd_val = 16'($urandom(69));
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    check_all();
    lfc_host_inst.rd_reg(8'h07, rd_val);
    `CHK(rd_val, 16'h0000)
    for (int i = 0; i < 64; i++) begin
      addr = (i < 4) ? 8'h08 : 8'h05 + 8'($urandom % 5);
      data = (i < 4) ? corner[i] : 16'($urandom);
      lfc_host_inst.wr_reg(addr, data);
      if (addr == 8'h06) fault_exp = data & 16'h010f;
      if (addr == 8'h08) irq_exp = irq_next(irq_exp, data);
      check_all();
    end
    // Clock enable low: both writes must be ignored.
    @(posedge clk_sys_i);
    clk_en_i <= 1'b0;
    lfc_host_inst.wr_reg(8'h08, 16'h1555);
    lfc_host_inst.wr_reg(8'h06, 16'h000f);
    clk_en_i <= 1'b1;
    check_all();
    // Reset in mid-run brings back the defaults.
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    fault_exp = 16'h0100;
    irq_exp = 7'h7f;
    check_all();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
